//--- mdc_cfg.svh
`ifndef MDC_CFG_SVH
`define MDC_CFG_SVH

// ------------------------------------------------------------------
// Sizes
// ------------------------------------------------------------------
`define MDC_MAX_DDS      32
`define MDC_MAX_MDS      4
`define MDC_SEL_W        5
`define MDC_CNT_W        6
`define MDC_STAT_W       16
`define MDC_IDX_W        4
`define MDC_THERM_W      8
`define MDC_CFG_W        3

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define MDC_RST_SET      5'h00
`define MDC_RST_WORD     16'h0000
`define MDC_INTERNAL_CFG 3'h0

`endif

//--- mdc_pkg.sv
`default_nettype none

package mdc_pkg;

   // Changeover sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE       = 6'h01,
      ST_INHIBIT    = 6'h02,
      ST_OPEN       = 6'h04,
      ST_SWITCH     = 6'h08,
      ST_WAIT_OPEN  = 6'h10,
      ST_WAIT_CLOSE = 6'h20
   } mdc_state_e;

endpackage

`default_nettype wire

//--- mdc_set_lookup.sv
`timescale 1ns/100ps
`default_nettype none
`include "mdc_cfg.svh"

module mdc_set_lookup #(
   parameter int MAX_DDS = `MDC_MAX_DDS,
   parameter int MAX_MDS = `MDC_MAX_MDS,
   parameter int MW      = 2
) (
   // Clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_srst,
   // Lookup index
   input  wire logic [`MDC_SEL_W-1:0]         i_drive_set,
   // Tables
   input  wire logic [MAX_DDS*MW-1:0]         i_drive_to_motor_set_map,
   input  wire logic [MAX_MDS*`MDC_IDX_W-1:0] i_contactor_status_bit_index,
   input  wire logic [MAX_MDS*`MDC_THERM_W-1:0] i_thermal_model_number,
   // Registered results
   output logic      [MW-1:0]                 o_motor_set,
   output logic      [`MDC_IDX_W-1:0]         o_bit_index,
   output logic      [`MDC_THERM_W-1:0]       o_thermal
);

   typedef struct packed {
      logic [MW-1:0]           mset;
      logic [`MDC_IDX_W-1:0]   idx;
      logic [`MDC_THERM_W-1:0] therm;
   } mdc_lk_s;

   mdc_lk_s lk_r;
   mdc_lk_s lk_nxt;
   logic [MW-1:0] mset;

   // ---------------------------------------------------------------
   // Two-level table walk: drive set -> motor set -> attributes
   // ---------------------------------------------------------------
   always_comb begin
      mset = '0;
      lk_nxt = lk_r;
      // [RL3] drive-to-motor map
      if (int'(i_drive_set) < MAX_DDS) begin
         mset = i_drive_to_motor_set_map[int'(i_drive_set)*MW +: MW];
      end
      lk_nxt.mset = mset;
      // [RL5] per-motor status bit
      lk_nxt.idx = i_contactor_status_bit_index[int'(mset)*`MDC_IDX_W +:
                                                `MDC_IDX_W];
      // [RL4] per-motor thermal model
      lk_nxt.therm = i_thermal_model_number[int'(mset)*`MDC_THERM_W +:
                                            `MDC_THERM_W];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         lk_r <= '0;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   assign o_motor_set = lk_r.mset;
   assign o_bit_index = lk_r.idx;
   assign o_thermal   = lk_r.therm;

endmodule

`default_nettype wire

//--- mdc_changeover.sv
`timescale 1ns/100ps
`default_nettype none
`include "mdc_cfg.svh"

// What this block does
// [RL1] Holds configurable counts of motor and drive sets, one pair for the whole block; i_motor_set_count is never read, only the drive set count is used.
// [RL2] Requested drive set is a five-bit binary index; unused bits tied low.
// [RL3] Table maps each drive set to the motor set it uses.
// [RL4] Each motor set has a thermal model number; equal numbers share.
// [RL5] Motor set's bit index picks which status word bit is raised.
// [RL6] Status word bits 1 to 4 drive the auxiliary contactor outputs.
// [RL7] One contactor feedback per motor set advances the sequence.
// [RL8] Config bits all zero: block runs contactors, pulses, and park bit.
// [RL9] Synchronous motors: request only below field weakening start speed.
// [RL10] A new drive set request first inhibits the power stage pulses.
// [RL11] Then all contactor outputs clear and changeover active flag sets.
// [RL12] Then the requested drive set becomes the effective one.
// [RL13] New contactor energized only after old contactor reports open.
// [RL14] Flag clears and pulses resume only after new contactor closes.
// [RL15] Star/delta: integrator drives select bit 0 from speed monitor.
// [RL16] Several motors with holding brakes: internal brake control unused.
// [RL17] Vector drives onto a rotating motor need flying restart enabled.
// [RL18] Missing feedback keeps pulses inhibited and flag set indefinitely.
// [RL19] Request equal to effective set starts nothing and changes nothing.
module mdc_changeover #(
   parameter int MAX_DDS = `MDC_MAX_DDS,
   parameter int MAX_MDS = `MDC_MAX_MDS
) (
   // Clock and reset
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_srst,
   // Configuration
   input  wire logic [`MDC_CNT_W-1:0]           i_motor_set_count,
   input  wire logic [`MDC_CNT_W-1:0]           i_drive_set_count,
   input  wire logic [MAX_DDS*((MAX_MDS>1)?$clog2(MAX_MDS):1)-1:0]
                                                i_drive_to_motor_set_map,
   input  wire logic [MAX_MDS*`MDC_THERM_W-1:0] i_thermal_model_number,
   input  wire logic [MAX_MDS*`MDC_IDX_W-1:0]   i_contactor_status_bit_index,
   input  wire logic [`MDC_CFG_W-1:0]           i_changeover_config,
   // Data set selection, bit 0 to bit 4
   input  wire logic [`MDC_SEL_W-1:0]           i_set_select,
   // Contactor feedback, high when closed
   input  wire logic [MAX_MDS-1:0]              i_contactor_feedback_input,
   // Power stage and contactors
   output logic                                 o_pulse_enable,
   output logic      [`MDC_STAT_W-1:0]          o_contactor_status_word,
   output logic      [MAX_MDS-1:0]              o_aux_contactor,
   // Status
   output logic                                 o_changeover_active_flag,
   output logic                                 o_park_status_bit,
   output logic      [`MDC_SEL_W-1:0]           o_effective_drive_set,
   output logic      [((MAX_MDS>1)?$clog2(MAX_MDS):1)-1:0]
                                                o_active_motor_set,
   output logic      [`MDC_THERM_W-1:0]         o_active_thermal_model
);

   localparam int MW     = (MAX_MDS > 1) ? $clog2(MAX_MDS) : 1;
   localparam int SW     = `MDC_SEL_W;
   localparam int STAT_W = `MDC_STAT_W;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // [RL1] set counts bounded
   if (MAX_DDS < 1 || MAX_DDS > (1 << SW)) begin : g_bad_dds
      $error("MAX_DDS must lie between 1 and 32");
   end
   // Bit 0 of the status word is reserved, so at most 15 motors
   if (MAX_MDS < 1 || MAX_MDS > STAT_W - 1) begin : g_bad_mds
      $error("MAX_MDS must lie between 1 and 15");
   end

   typedef struct packed {
      mdc_pkg::mdc_state_e state;
      logic [SW-1:0]       req;
      logic [SW-1:0]       eff;
      logic [MW-1:0]       old_mset;
      logic [STAT_W-1:0]   word;
      logic                active;
      logic                pulse;
      logic                park;
   } mdc_st_s;

   mdc_st_s st_r;
   mdc_st_s st_nxt;

   logic [MW-1:0]           lk_mset;
   logic [`MDC_IDX_W-1:0]   lk_idx;
   logic [`MDC_THERM_W-1:0] lk_therm;
   logic                    sel_valid;
   logic                    internal;
   logic                    old_open;
   logic                    new_closed;

   // ---------------------------------------------------------------
   // Table lookup, indexed by the requested set
   // ---------------------------------------------------------------
   mdc_set_lookup #(
      .MAX_DDS (MAX_DDS),
      .MAX_MDS (MAX_MDS),
      .MW      (MW)
   ) u_lookup (
      .i_sys_clk                    (i_sys_clk),
      .i_srst                       (i_srst),
      .i_drive_set                  (st_r.req),
      .i_drive_to_motor_set_map     (i_drive_to_motor_set_map),
      .i_contactor_status_bit_index (i_contactor_status_bit_index),
      .i_thermal_model_number       (i_thermal_model_number),
      .o_motor_set                  (lk_mset),
      .o_bit_index                  (lk_idx),
      .o_thermal                    (lk_therm)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // [RL2] index must fall inside the configured drive sets
   assign sel_valid  = ({1'b0, i_set_select} < i_drive_set_count) &&
                       (int'(i_set_select) < MAX_DDS);
   // [RL8] all three config bits clear selects internal control
   assign internal   = (i_changeover_config == `MDC_INTERNAL_CFG);
   // [RL7] feedback of the outgoing and incoming motor
   assign old_open   = !i_contactor_feedback_input[st_r.old_mset];
   assign new_closed = i_contactor_feedback_input[lk_mset];

   always_comb begin
      st_nxt = st_r;
      unique case (st_r.state)
         mdc_pkg::ST_IDLE: begin
            // [RL19] same set ignored
            if (sel_valid && i_set_select != st_r.eff) begin
               st_nxt.req = i_set_select;
               if (internal) begin
                  // [RL10] inhibit pulses first
                  st_nxt.pulse = 1'b0;
                  st_nxt.park  = 1'b1;
                  st_nxt.state = mdc_pkg::ST_INHIBIT;
               end else begin
                  // External control owns contactors and pulses
                  st_nxt.eff = i_set_select;
               end
            end
         end
         mdc_pkg::ST_INHIBIT: begin
            // Lookup still shows the outgoing motor here
            st_nxt.old_mset = lk_mset;
            st_nxt.state    = mdc_pkg::ST_OPEN;
         end
         mdc_pkg::ST_OPEN: begin
            // [RL11] open contactor, flag active
            st_nxt.word   = '0;
            st_nxt.active = 1'b1;
            st_nxt.state  = mdc_pkg::ST_SWITCH;
         end
         mdc_pkg::ST_SWITCH: begin
            // [RL12] requested set effective
            st_nxt.eff   = st_r.req;
            st_nxt.state = mdc_pkg::ST_WAIT_OPEN;
         end
         mdc_pkg::ST_WAIT_OPEN: begin
            // [RL13] energize after open feedback
            if (old_open) begin
               st_nxt.word  = STAT_W'(1) << lk_idx;
               st_nxt.state = mdc_pkg::ST_WAIT_CLOSE;
            end
         end
         mdc_pkg::ST_WAIT_CLOSE: begin
            // [RL14] end after close feedback
            // [RL18] no timeout: waits with pulses off
            if (new_closed) begin
               st_nxt.active = 1'b0;
               st_nxt.pulse  = 1'b1;
               st_nxt.park   = 1'b0;
               st_nxt.state  = mdc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // Reset runs a full changeover onto set 0 so the contactors
   // start from a known, confirmed position
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_r.state    <= mdc_pkg::ST_INHIBIT;
         st_r.req      <= `MDC_RST_SET;
         st_r.eff      <= `MDC_RST_SET;
         st_r.old_mset <= '0;
         st_r.word     <= `MDC_RST_WORD;
         st_r.active   <= 1'b1;
         st_r.pulse    <= 1'b0;
         st_r.park     <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_pulse_enable           = st_r.pulse;
   assign o_contactor_status_word  = st_r.word;
   // [RL6] bits 1.. to auxiliary contactors
   assign o_aux_contactor          = st_r.word[MAX_MDS:1];
   assign o_changeover_active_flag = st_r.active;
   // [RL8] park bit rises with the pulse inhibit, ahead of the flag
   assign o_park_status_bit        = st_r.park;
   assign o_effective_drive_set    = st_r.eff;
   assign o_active_motor_set       = lk_mset;
   assign o_active_thermal_model   = lk_therm;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_new_request;
      st_r.state == mdc_pkg::ST_IDLE && sel_valid && internal &&
      i_set_select != st_r.eff;
   endsequence

   sequence s_open_then_switch;
      (st_r.word == '0 && st_r.active && !st_r.pulse) ##1
      (st_r.eff == st_r.req);
   endsequence

   a_inhibit_first: assert property ( // [RL10]
      s_new_request |=> !st_r.pulse && st_r.word == $past(st_r.word))
      else $error("pulses not inhibited before contactor action");

   a_open_clears: assert property ( // [RL11]
      s_new_request |-> ##3 s_open_then_switch)
      else $error("contactor open or set switch out of order");

   a_switch_eff: assert property ( // [RL12]
      st_r.state == mdc_pkg::ST_SWITCH |=> o_effective_drive_set == st_r.req)
      else $error("effective set not the requested one");

   a_close_after_open: assert property ( // [RL13]
      $rose(|st_r.word) |-> $past(old_open) &&
      $past(st_r.state == mdc_pkg::ST_WAIT_OPEN))
      else $error("new contactor energized before old one opened");

   a_pulse_after_close: assert property ( // [RL14]
      $rose(st_r.pulse) |-> $past(new_closed) && !st_r.active)
      else $error("pulses enabled without close feedback");

   a_hold_inhibit: assert property ( // [RL18]
      st_r.state == mdc_pkg::ST_WAIT_CLOSE && !new_closed |=>
      !st_r.pulse && st_r.active)
      else $error("pulses enabled while feedback missing");

   a_same_set_idle: assert property ( // [RL19]
      st_r.state == mdc_pkg::ST_IDLE && i_set_select == st_r.eff |=>
      $stable(st_r.pulse) && $stable(st_r.word) && $stable(st_r.eff))
      else $error("same set request changed outputs");

   a_park_during: assert property ( // [RL8]
      st_r.state != mdc_pkg::ST_IDLE |-> o_park_status_bit && !o_pulse_enable)
      else $error("park bit or pulses wrong during changeover");

   a_one_contactor: assert property ( // [RL5]
      $onehot0(st_r.word) && !st_r.word[0])
      else $error("more than one motor contactor energized");

   a_park_flag: assert property ( // [RL8]
      st_r.active |-> o_park_status_bit)
      else $error("changeover active without park bit");

   a_ext_hands_off: assert property ( // [RL8]
      st_r.state == mdc_pkg::ST_IDLE && !internal |=>
      $stable(st_r.pulse) && $stable(st_r.word) && $stable(st_r.park))
      else $error("external mode touched pulses or contactors");

   a_ignore_bad: assert property ( // [RL2]
      st_r.state == mdc_pkg::ST_IDLE && !sel_valid |=>
      $stable(st_r.eff) && $stable(st_r.pulse) && $stable(st_r.word))
      else $error("invalid set request acted on");

   a_req_taken: assert property ( // [RL2]
      s_new_request |=> st_r.req == $past(i_set_select))
      else $error("requested set not captured");

   a_old_captured: assert property ( // [RL7]
      st_r.state == mdc_pkg::ST_INHIBIT |=> st_r.old_mset == $past(lk_mset))
      else $error("outgoing motor not captured");

   a_eff_only_switch: assert property ( // [RL12]
      st_r.state != mdc_pkg::ST_IDLE && st_r.state != mdc_pkg::ST_SWITCH |=>
      $stable(st_r.eff))
      else $error("effective set moved outside the switch step");

   a_word_wait: assert property ( // [RL13]
      st_r.state == mdc_pkg::ST_WAIT_OPEN && !old_open |=>
      st_r.word == '0 && st_r.state == mdc_pkg::ST_WAIT_OPEN)
      else $error("new contactor energized without open feedback");

   a_flag_no_early: assert property ( // [RL14]
      $fell(st_r.active) |->
      $past(st_r.state == mdc_pkg::ST_WAIT_CLOSE) && $past(new_closed))
      else $error("changeover flag cleared without close feedback");

endmodule

`default_nettype wire

//--- mdc_contactor_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Motor contactors with auxiliary feedback contacts
// ------------------------------------------------------------------
module mdc_contactor_model (
   // Clock
   input  wire logic       i_sys_clk,
   // Coil commands and a stuck-contact fault
   input  wire logic [3:0] i_coil,
   input  wire logic       i_stick,
   // Feedback, high when closed
   output var  logic [3:0] o_fb
);
   logic [3:0] d1_r;
   logic [3:0] d2_r;

   // Feedback follows coils
   // Mechanical lag of three cycles; a stuck contact freezes all feedback
   always_ff @(posedge i_sys_clk) begin
      d1_r <= i_coil;
      d2_r <= d1_r;
      if (!i_stick) begin
         o_fb <= d2_r;
      end
   end
endmodule

`default_nettype wire

//--- tb_motor_data_set_changeover.sv
`timescale 1ns/100ps
`default_nettype none

module tb_motor_data_set_changeover;
   logic        i_sys_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic [4:0]  sel = 5'h00;
   logic [2:0]  cfg = 3'h0;
   logic        stick = 1'b0;
   logic [63:0] map;
   logic [31:0] therm;
   logic [15:0] bidx;
   logic [3:0]  fb;
   logic        pulse;
   logic [15:0] word;
   logic [3:0]  aux;
   logic        active;
   logic        park;
   logic [4:0]  eff;
   logic [1:0]  mset;
   logic [7:0]  tmod;
   int          fails = 0;
   int          n_checks = 0;

   always #2 i_sys_clk = ~i_sys_clk;

   // Drive set d uses motor d mod 4; motor m raises bit m+1
   initial begin
      for (int d = 0; d < 32; d++) begin
         map[d*2 +: 2] = 2'(d % 4);
      end
      for (int m = 0; m < 4; m++) begin
         therm[m*8 +: 8] = 8'(m + 1);
         bidx[m*4 +: 4]  = 4'(m + 1);
      end
   end

   mdc_changeover mdc_changeover_i (
      .i_sys_clk                    (i_sys_clk),
      .i_srst                       (i_srst),
      .i_motor_set_count            (6'h04),
      .i_drive_set_count            (6'h14),
      .i_drive_to_motor_set_map     (map),
      .i_thermal_model_number       (therm),
      .i_contactor_status_bit_index (bidx),
      .i_changeover_config          (cfg),
      .i_set_select                 (sel),
      .i_contactor_feedback_input   (fb),
      .o_pulse_enable               (pulse),
      .o_contactor_status_word      (word),
      .o_aux_contactor              (aux),
      .o_changeover_active_flag     (active),
      .o_park_status_bit            (park),
      .o_effective_drive_set        (eff),
      .o_active_motor_set           (mset),
      .o_active_thermal_model       (tmod)
   );

   mdc_contactor_model mdc_contactor_model_i (
      .i_sys_clk (i_sys_clk),
      .i_coil    (aux),
      .i_stick   (stick),
      .o_fb      (fb)
   );

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   function automatic logic cond(input int k);
      case (k)
         0: return pulse === 1'b0;
         1: return active === 1'b1;
         2: return eff === sel;
         3: return word !== 16'h0000;
         default: return pulse === 1'b1;
      endcase
   endfunction

   // Bounded wait; running out counts a mismatch and ends the run
   task automatic wait_c(input int k);
      for (int i = 0; i < 200 && !cond(k); i++) begin
         step(1);
      end
      if (!cond(k)) begin
         chk(1'b0, "wait timed out");
         finish_test();
      end
   endtask

   task automatic set_sel(input logic [4:0] v);
      @(posedge i_sys_clk);
      sel <= v;
      #1;
   endtask

   task automatic change(input logic [4:0] s, input int mo, input int mn);
      logic [15:0] w0;
      w0 = word;
      set_sel(s);
      wait_c(0);
      chk(word === w0, "contactor moved before inhibit");
      wait_c(1);
      chk(word === 16'h0000 && park === 1'b1, "open phase");
      wait_c(2);
      chk(pulse === 1'b0 && mset === 2'(mn), "set switch");
      wait_c(3);
      chk(fb[mo] === 1'b0, "new coil before old opened");
      chk(word === 16'(16'h0001 << (mn + 1)), "status bit");
      wait_c(4);
      chk(active === 1'b0 && fb[mn] === 1'b1, "end of change");
      chk(aux === 4'(4'h1 << mn) && park === 1'b0, "aux out");
      chk(tmod === 8'(mn + 1), "thermal model");
      $display("test change to %0d done", s);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      step(8);
      chk(pulse === 1'b0 && word === 16'h0000, "reset outputs");
      chk(active === 1'b1 && eff === 5'h00, "reset flags");
      @(posedge i_sys_clk);
      i_srst <= 1'b0;
      wait_c(4);
      chk(word === 16'h0002 && active === 1'b0, "startup set 0");
      $display("test startup done");
      // Requests stand for a motor at rest, no brake
      change(5'h02, 0, 2);
      change(5'h11, 2, 1);
      change(5'h03, 1, 3);
      @(posedge i_sys_clk);
      stick <= 1'b1;
      set_sel(5'h00);
      step(60);
      chk(pulse === 1'b0 && active === 1'b1, "stuck feedback");
      chk(park === 1'b1 && word === 16'h0000, "stuck coils off");
      @(posedge i_sys_clk);
      stick <= 1'b0;
      wait_c(4);
      chk(word === 16'h0002 && active === 1'b0, "recovered");
      $display("test stuck feedback done");
      set_sel(5'h00);
      step(20);
      chk(pulse === 1'b1 && word === 16'h0002, "same set");
      set_sel(5'h19);
      step(20);
      chk(pulse === 1'b1 && eff === 5'h00, "invalid set request");
      $display("test ignored requests done");
      // Star to delta: set 0 to set 1, only select bit 0 differs from the effective set, as a speed monitor would drive
      change(5'h01, 0, 1);
      $display("test star delta done");
      @(posedge i_sys_clk);
      cfg <= 3'h1;
      set_sel(5'h03);
      wait_c(2);
      step(10);
      chk(pulse === 1'b1 && word === 16'h0004, "external mode");
      chk(park === 1'b0 && active === 1'b0, "external flags");
      $display("test external config done");
      finish_test();
   end
endmodule

`default_nettype wire
